/* verilog/itx_map.svh */
`ifndef ITX_MAP_SVH
`define ITX_MAP_SVH
// Register byte offsets on the bus.
`define ITX_OFS_CTRL 12'h000
`define ITX_OFS_STAT 12'h004
`define ITX_OFS_DATA 12'h008
`define ITX_OFS_OWN 12'h00C
// Bit positions inside the serial control register.
`define ITX_B_AA 0
`define ITX_B_SI 1
`define ITX_B_STO 2
`define ITX_B_STA 3
// Reset value of every byte register.
`define ITX_RST_BYTE 8'h00
// State codes.
`define ITX_C_BERR 8'h00
`define ITX_C_STRT 8'h08
`define ITX_C_RSTRT 8'h10
`define ITX_C_MW_ACK 8'h18
`define ITX_C_MW_NAK 8'h20
`define ITX_C_ARB 8'h38
`define ITX_C_MR_ACK 8'h40
`define ITX_C_MR_NAK 8'h48
`define ITX_C_SL_SEL 8'hA8
`define ITX_C_SL_ARB 8'hB0
`define ITX_C_SL_ACK 8'hB8
`define ITX_C_SL_NAK 8'hC0
`define ITX_C_SL_LAST 8'hC8
`define ITX_C_IDLE 8'hF8
// Timing: half of a generated bus clock period, and pulses per retry.
`define ITX_CLK_MHZ 20
`define ITX_HALF_NS 2500
`define ITX_HALF_CYC ((`ITX_HALF_NS * `ITX_CLK_MHZ + 999) / 1000)
`define ITX_PULSES 2
`endif

/* verilog/itx_pkg.sv */
`default_nettype none
package itx_pkg;
	// Serial unit states, one-hot.
	typedef enum logic [13:0] {
		ST_IDLE = 14'h0001,
		ST_ADDR = 14'h0002,
		ST_ACKA = 14'h0004,
		ST_WAIT = 14'h0008,
		ST_TXB = 14'h0010,
		ST_RACK = 14'h0020,
		ST_WEND = 14'h0040,
		ST_ERR = 14'h0080,
		ST_MSTART = 14'h0100,
		ST_MPULSE = 14'h0200,
		ST_MSTRT2 = 14'h0400,
		ST_MHOLD = 14'h0800,
		ST_MADDR = 14'h1000,
		ST_MSTOP = 14'h2000
	} itx_state_e;
	typedef logic [7:0] itx_byte_t;
endpackage
`default_nettype wire

/* verilog/itx_sync.sv */
`default_nettype none
module itx_sync (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o,
	output logic scl_rise_o,
	output logic scl_fall_o,
	output logic start_o,
	output logic stop_o
);
	logic [1:0] meta_q;
	logic [1:0] stab_q;
	logic [1:0] prev_q;

	// Two stages per line; the idle bus level is high on both.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= 2'h3;
			stab_q <= 2'h3;
			prev_q <= 2'h3;
		end else begin
			meta_q <= {sda_i, scl_i};
			stab_q <= meta_q;
			prev_q <= stab_q;
		end
	end

	// Edges and conditions look only at stable samples.
	assign scl_o = stab_q[0];
	assign sda_o = stab_q[1];
	assign scl_rise_o = stab_q[0] & ~prev_q[0];
	assign scl_fall_o = ~stab_q[0] & prev_q[0];
	assign start_o = stab_q[0] & prev_q[0] & prev_q[1] & ~stab_q[1];
	assign stop_o = stab_q[0] & prev_q[0] & ~prev_q[1] & stab_q[1];
endmodule
`default_nettype wire

/* verilog/itx_top.sv */
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`include "itx_map.svh"
`default_nettype none
module itx_top import itx_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o
);
	localparam logic [7:0] HALF = 8'(`ITX_HALF_CYC);
	localparam logic [3:0] PLAST = 4'(`ITX_PULSES - 1);

	itx_state_e st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	itx_byte_t sh_q, sh_d, data_q, own_q, code_q, code_d;
	logic [7:0] tmr_q, tmr_d;
	logic ph_q, ph_d, arb_q, arb_d, last_q, last_d, nack_q, nack_d;
	logic rep_q, rep_d, pulsed_q, pulsed_d, adone_q, adone_d;
	logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
	logic aa_q, si_q, sto_q, sta_q, busy_q, lo_q;
	logic si_set, sto_clr, force_free;
	logic wr_pend_q, rd_pend_q, hready_q;
	logic [11:0] wa_q;
	logic [31:0] hrdata_q;
	logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;

	itx_sync u_sync (
		.clk_i(sys_clk_i),
		.rst_n_i(reset_n_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.scl_o(scl_s),
		.sda_o(sda_s),
		.scl_rise_o(scl_rise),
		.scl_fall_o(scl_fall),
		.start_o(start_det),
		.stop_o(stop_det)
	);

	// Bus decode. Writes land in the data phase; reads take one wait state.
	wire acc = hsel_i & hready_i & htrans_i[1];
	wire wr_ctrl = wr_pend_q & (wa_q == `ITX_OFS_CTRL);
	wire wr_data = wr_pend_q & (wa_q == `ITX_OFS_DATA);
	wire wr_own = wr_pend_q & (wa_q == `ITX_OFS_OWN);
	wire si_clr = wr_ctrl & ~hwdata_i[`ITX_B_SI] & si_q;
	wire [7:0] stat_rd = si_q ? code_q : `ITX_C_IDLE;
	wire [31:0] rd_val = (wa_q == `ITX_OFS_CTRL) ? {28'h0000_000, sta_q, sto_q, si_q, aa_q} :
		(wa_q == `ITX_OFS_STAT) ? {24'h00_0000, stat_rd} :
		(wa_q == `ITX_OFS_DATA) ? {24'h00_0000, data_q} :
		(wa_q == `ITX_OFS_OWN) ? {24'h00_0000, own_q} : 32'h0000_0000;

	// Address match needs the enable bit at the moment of decision.
	wire own_hit = aa_q & (sh_q[7:1] == own_q[7:1]) & sh_q[0];
	wire involved = (st_q == ST_ACKA) | (st_q == ST_TXB) | (st_q == ST_RACK) |
		(st_q == ST_MADDR) | ((st_q == ST_ADDR) & arb_q);
	wire bus_err = (start_det | stop_det) & involved;
	wire [7:0] tmr_dn = tmr_q - 8'h01;
	wire [3:0] cnt_up = cnt_q + 4'h1;

	// Main sequencer. SDA only moves one cycle after SCL is low, so the
	// unit never makes a false START or STOP of its own.
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		tmr_d = tmr_q;
		ph_d = ph_q;
		arb_d = arb_q;
		last_d = last_q;
		nack_d = nack_q;
		rep_d = rep_q;
		pulsed_d = pulsed_q;
		adone_d = adone_q;
		scl_oe_d = scl_oe_q;
		sda_oe_d = sda_oe_q;
		code_d = code_q;
		si_set = 1'b0;
		sto_clr = 1'b0;
		force_free = 1'b0;
		if (bus_err) begin
			st_d = ST_ERR;
			scl_oe_d = 1'b0;
			sda_oe_d = 1'b0;
			si_set = 1'b1;
			code_d = `ITX_C_BERR;
			arb_d = 1'b0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					scl_oe_d = 1'b0;
					sda_oe_d = 1'b0;
					arb_d = 1'b0;
					rep_d = 1'b0;
					pulsed_d = 1'b0;
					if (start_det) begin
						st_d = ST_ADDR;
						cnt_d = 4'h0;
					end else if (sta_q & sto_q & busy_q) begin
						force_free = 1'b1;
						sto_clr = 1'b1;
					end else if (sta_q & ~busy_q & ~si_q) begin
						st_d = ST_MSTART;
						tmr_d = HALF;
					end
				end
				ST_ADDR: begin
					if (start_det) begin
						cnt_d = 4'h0;
					end else if (stop_det) begin
						st_d = ST_IDLE;
					end else if (sta_q & sto_q & ~arb_q) begin
						// A frame that never ends would otherwise lock out a forced access.
						force_free = 1'b1;
						sto_clr = 1'b1;
						st_d = ST_IDLE;
					end else if (scl_rise & (cnt_q != 4'h8)) begin
						sh_d = {sh_q[6:0], sda_s};
						cnt_d = cnt_up;
					end else if (scl_fall & (cnt_q == 4'h8)) begin
						if (own_hit) begin
							st_d = ST_ACKA;
							sda_oe_d = 1'b1;
						end else if (arb_q) begin
							st_d = ST_WEND;
							si_set = 1'b1;
							code_d = `ITX_C_ARB;
						end else begin
							st_d = ST_IDLE;
						end
					end
				end
				ST_ACKA: begin
					if (scl_fall) begin
						sda_oe_d = 1'b0;
						scl_oe_d = 1'b1;
						si_set = 1'b1;
						code_d = arb_q ? `ITX_C_SL_ARB : `ITX_C_SL_SEL;
						arb_d = 1'b0;
						st_d = ST_WAIT;
					end
				end
				ST_WAIT: begin
					scl_oe_d = 1'b1;
					if (si_clr) begin
						sh_d = data_q;
						cnt_d = 4'h0;
						last_d = ~hwdata_i[`ITX_B_AA];
						sda_oe_d = ~data_q[7];
						st_d = ST_TXB;
					end
				end
				ST_TXB: begin
					scl_oe_d = 1'b0;
					if (scl_fall) begin
						cnt_d = cnt_up;
						sh_d = {sh_q[6:0], 1'b0};
						sda_oe_d = (cnt_q == 4'h7) ? 1'b0 : ~sh_q[6];
						if (cnt_q == 4'h7) begin
							st_d = ST_RACK;
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						nack_d = sda_s;
					end
					if (scl_fall) begin
						si_set = 1'b1;
						if (nack_q) begin
							code_d = `ITX_C_SL_NAK;
							st_d = ST_WEND;
						end else if (last_q) begin
							code_d = `ITX_C_SL_LAST;
							st_d = ST_WEND;
						end else begin
							code_d = `ITX_C_SL_ACK;
							scl_oe_d = 1'b1;
							st_d = ST_WAIT;
						end
					end
				end
				ST_WEND: begin
					scl_oe_d = 1'b0;
					sda_oe_d = 1'b0;
					if (si_clr) begin
						st_d = ST_IDLE;
					end
				end
				ST_ERR: begin
					if (si_clr) begin
						st_d = ST_IDLE;
						sto_clr = 1'b1;
					end
				end
				ST_MSTART: begin
					scl_oe_d = 1'b0;
					sda_oe_d = 1'b0;
					if (start_det) begin
						st_d = ST_IDLE;
					end else if (tmr_q != 8'h00) begin
						if (scl_s) begin
							tmr_d = tmr_dn;
						end
					end else if (~scl_s) begin
						st_d = ST_MSTART;
					end else if (~sda_s) begin
						st_d = ST_MPULSE;
						cnt_d = 4'h0;
						pulsed_d = 1'b1;
						scl_oe_d = 1'b1;
						tmr_d = HALF;
					end else begin
						sda_oe_d = 1'b1;
						tmr_d = HALF;
						st_d = ST_MSTRT2;
					end
				end
				ST_MPULSE: begin
					if (tmr_q != 8'h00) begin
						if (scl_s | scl_oe_q) begin
							tmr_d = tmr_dn;
						end
					end else if (scl_oe_q) begin
						scl_oe_d = 1'b0;
						tmr_d = HALF;
					end else if (cnt_q == PLAST) begin
						st_d = ST_MSTART;
						tmr_d = HALF;
					end else begin
						cnt_d = cnt_up;
						scl_oe_d = 1'b1;
						tmr_d = HALF;
					end
				end
				ST_MSTRT2: begin
					sda_oe_d = 1'b1;
					if (tmr_q != 8'h00) begin
						tmr_d = tmr_dn;
					end else begin
						scl_oe_d = 1'b1;
						si_set = 1'b1;
						code_d = (rep_q & ~pulsed_q) ? `ITX_C_RSTRT : `ITX_C_STRT;
						adone_d = 1'b0;
						st_d = ST_MHOLD;
					end
				end
				ST_MHOLD: begin
					scl_oe_d = 1'b1;
					if (si_clr) begin
						ph_d = 1'b0;
						tmr_d = HALF;
						if (hwdata_i[`ITX_B_STO]) begin
							sda_oe_d = 1'b1;
							st_d = ST_MSTOP;
						end else if (hwdata_i[`ITX_B_STA] & adone_q) begin
							sda_oe_d = 1'b0;
							rep_d = 1'b1;
							pulsed_d = 1'b0;
							st_d = ST_MSTART;
						end else if (~adone_q) begin
							sh_d = data_q;
							cnt_d = 4'h0;
							st_d = ST_MADDR;
						end
					end
				end
				ST_MADDR: begin
					if (~ph_q) begin
						scl_oe_d = 1'b1;
						sda_oe_d = (cnt_q != 4'h8) & ~sh_q[7];
						if (tmr_q != 8'h00) begin
							tmr_d = tmr_dn;
						end else begin
							scl_oe_d = 1'b0;
							ph_d = 1'b1;
							tmr_d = HALF;
						end
					end else if (tmr_q != 8'h00) begin
						if (scl_s) begin
							tmr_d = tmr_dn;
						end
					end else if (cnt_q == 4'h8) begin
						scl_oe_d = 1'b1;
						si_set = 1'b1;
						adone_d = 1'b1;
						st_d = ST_MHOLD;
						code_d = sh_q[0] ? (sda_s ? `ITX_C_MR_NAK : `ITX_C_MR_ACK) :
							(sda_s ? `ITX_C_MW_NAK : `ITX_C_MW_ACK);
					end else begin
						sh_d = {sh_q[6:0], sda_s};
						cnt_d = cnt_up;
						if (sh_q[7] & ~sda_s) begin
							arb_d = 1'b1;
							sda_oe_d = 1'b0;
							st_d = ST_ADDR;
						end else begin
							scl_oe_d = 1'b1;
							ph_d = 1'b0;
							tmr_d = HALF;
						end
					end
				end
				ST_MSTOP: begin
					if (tmr_q != 8'h00) begin
						if (scl_s | ~ph_q) begin
							tmr_d = tmr_dn;
						end
					end else if (~ph_q) begin
						scl_oe_d = 1'b0;
						ph_d = 1'b1;
						tmr_d = HALF;
					end else begin
						sda_oe_d = 1'b0;
						sto_clr = 1'b1;
						st_d = ST_IDLE;
					end
				end
				default: begin
					st_d = ST_IDLE;
				end
			endcase
		end
	end

	// Sequencer state.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q <= ST_IDLE;
			{cnt_q, sh_q, tmr_q} <= 20'h0_0000;
			{ph_q, arb_q, last_q, nack_q, rep_q, pulsed_q, adone_q} <= 7'h00;
			{scl_oe_q, sda_oe_q} <= 2'h0;
		end else begin
			st_q <= st_d;
			{cnt_q, sh_q, tmr_q} <= {cnt_d, sh_d, tmr_d};
			{ph_q, arb_q, last_q, nack_q, rep_q, pulsed_q, adone_q} <=
				{ph_d, arb_d, last_d, nack_d, rep_d, pulsed_d, adone_d};
			{scl_oe_q, sda_oe_q} <= {scl_oe_d, sda_oe_d};
		end
	end

	// Software flags. The event flag is set by hardware over a clear; the
	// stop request write that ends an error is itself cleared by hardware.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			{aa_q, si_q, sto_q, sta_q, busy_q} <= 5'h00;
			{data_q, own_q, code_q} <= {`ITX_RST_BYTE, `ITX_RST_BYTE, `ITX_RST_BYTE};
		end else begin
			si_q <= si_set | (si_q & ~si_clr);
			code_q <= si_set ? code_d : code_q;
			busy_q <= start_det | (busy_q & ~stop_det & ~force_free);
			aa_q <= wr_ctrl ? hwdata_i[`ITX_B_AA] : aa_q;
			sta_q <= wr_ctrl ? hwdata_i[`ITX_B_STA] : sta_q;
			sto_q <= wr_ctrl ? (hwdata_i[`ITX_B_STO] & ~sto_clr) : (sto_q & ~sto_clr);
			data_q <= wr_data ? hwdata_i[7:0] : data_q;
			own_q <= wr_own ? hwdata_i[7:0] : own_q;
		end
	end

	// Bus slave pipeline; the response is always OKAY.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			{wr_pend_q, rd_pend_q, lo_q} <= 3'h0;
			hready_q <= 1'b1;
			wa_q <= 12'h000;
			hrdata_q <= 32'h0000_0000;
		end else begin
			wr_pend_q <= acc & hwrite_i;
			rd_pend_q <= acc & ~hwrite_i;
			hready_q <= ~(acc & ~hwrite_i);
			wa_q <= acc ? haddr_i[11:0] : wa_q;
			hrdata_q <= rd_pend_q ? rd_val : hrdata_q;
			lo_q <= 1'b0;
		end
	end

	assign hrdata_o = hrdata_q;
	assign hreadyout_o = hready_q;
	assign hresp_o = lo_q;
	assign scl_o = lo_q;
	assign sda_o = lo_q;
	assign scl_oe_o = scl_oe_q;
	assign sda_oe_o = sda_oe_q;

	// Checks on the sequencer.
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_addr_end;
		st_q == ST_ACKA && scl_fall;
	endsequence
	sequence s_rack_end;
		st_q == ST_RACK && scl_fall;
	endsequence
	chk_sel_flag: assert property (s_addr_end |=> si_q && stat_rd != `ITX_C_IDLE)
		else $error("selection did not raise the event flag");
	chk_sel_code: assert property (s_addr_end ##0 !arb_q |=> code_q == `ITX_C_SL_SEL)
		else $error("selection code wrong");
	chk_arb_code: assert property (s_addr_end ##0 arb_q |=> code_q == `ITX_C_SL_ARB)
		else $error("selection after lost arbitration code wrong");
	chk_ack_next: assert property (s_rack_end ##0 !nack_q && !last_q |=> code_q == `ITX_C_SL_ACK ##0 st_q == ST_WAIT)
		else $error("acknowledged byte handling wrong");
	chk_last_mark: assert property (st_q == ST_WAIT && si_clr |=> last_q == !$past(hwdata_i[`ITX_B_AA]))
		else $error("final byte mark wrong");
	chk_nak_end: assert property (s_rack_end ##0 nack_q |=> code_q == `ITX_C_SL_NAK ##1 !scl_oe_q)
		else $error("unacknowledged byte handling wrong");
	chk_last_code: assert property (s_rack_end ##0 !nack_q && last_q |=> code_q == `ITX_C_SL_LAST)
		else $error("final byte code wrong");
	chk_gate_addr: assert property (st_q == ST_ADDR && scl_fall && cnt_q == 4'h8 && !aa_q |=> !sda_oe_q)
		else $error("address acknowledged while disabled");
	chk_idle_stat: assert property (!si_q && rd_pend_q && wa_q == `ITX_OFS_STAT |=> hrdata_q == {24'h00_0000, `ITX_C_IDLE})
		else $error("status not idle with flag clear");
	chk_err_code: assert property (bus_err |=> si_q && code_q == `ITX_C_BERR && !scl_oe_q && !sda_oe_q)
		else $error("bus error handling wrong");
	chk_err_exit: assert property (st_q == ST_ERR && si_clr |=> st_q == ST_IDLE && !sto_q)
		else $error("error recovery wrong");
	chk_force_free: assert property (force_free |=> !busy_q && !sto_q)
		else $error("forced access wrong");
	chk_wait_hold: assert property (st_q == ST_WAIT && !si_clr |=> scl_oe_q [*2])
		else $error("clock not stretched while waiting");
endmodule
`default_nettype wire

/* dv/itx_bus_model.sv */
`default_nettype none
module itx_bus_model (
	input wire logic scl_i,
	input wire logic sda_i,
	output var logic scl_oe_o,
	output var logic sda_oe_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// A quarter of the 400 ns link clock period.
	localparam int Q = 100;
	initial begin
		scl_oe_o = 1'b0;
		sda_oe_o = 1'b0;
	end
	// SCL is released and then awaited, because the slave may stretch the low phase.
	task automatic rise();
		scl_oe_o = 1'b0;
		wait (scl_i === 1'b1);
	endtask
	// Works from an idle bus and inside a frame alike, so it also makes a repeated START.
	task automatic start();
		sda_oe_o = 1'b0;
		#Q;
		rise();
		#(2 * Q);
		sda_oe_o = 1'b1;
		#(2 * Q);
		scl_oe_o = 1'b1;
	endtask
	task automatic stop();
		scl_oe_o = 1'b1;
		sda_oe_o = 1'b1;
		#(2 * Q);
		rise();
		#(2 * Q);
		sda_oe_o = 1'b0;
		#(2 * Q);
	endtask
	task automatic write_bit(input logic b);
		#Q;
		sda_oe_o = !b;
		#Q;
		rise();
		#(2 * Q);
		scl_oe_o = 1'b1;
	endtask
	task automatic read_bit(output logic b);
		sda_oe_o = 1'b0;
		#(2 * Q);
		rise();
		#Q;
		b = sda_i;
		#Q;
		scl_oe_o = 1'b1;
	endtask
	task automatic send_byte(input logic [7:0] v, output logic ack_n);
		for (int i = 7; i >= 0; i--) begin
			write_bit(v[i]);
		end
		read_bit(ack_n);
	endtask
	task automatic recv_byte(output logic [7:0] v, input logic ack_n);
		for (int i = 7; i >= 0; i--) begin
			read_bit(v[i]);
		end
		write_bit(ack_n);
	endtask
	// SDA goes low only while SCL is low, so the bus stays free but obstructed.
	task automatic hold_sda();
		scl_oe_o = 1'b1;
		#Q;
		sda_oe_o = 1'b1;
		#Q;
		scl_oe_o = 1'b0;
	endtask
	// SDA is let go first, so leaving a frame this way shows no STOP.
	task automatic release_all();
		sda_oe_o = 1'b0;
		#Q;
		scl_oe_o = 1'b0;
		#(2 * Q);
	endtask
endmodule
`default_nettype wire

/* dv/test_itx_top.sv */
`include "itx_map.svh"
`default_nettype none
module test_itx_top import itx_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk, reset_n, hsel, hwrite;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, v;
	logic [7:0] b;
	logic ack_n, bit_v, prev;
	wire logic [31:0] hrdata;
	wire logic hreadyout, hresp, scl_oe, sda_oe, m_scl_oe, m_sda_oe, scl_line, sda_line, scl_dout, sda_dout;
	int failures = 0;
	int tests_run = 0;
	int falls;
	// Open-drain wiring with pull-ups: a line is low while any party pulls it.
	assign scl_line = !(scl_oe | m_scl_oe);
	assign sda_line = !(sda_oe | m_sda_oe);
	itx_top itx_top_inst (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout),
		.hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .scl_i(scl_line), .scl_o(scl_dout),
		.scl_oe_o(scl_oe), .sda_i(sda_line), .sda_o(sda_dout), .sda_oe_o(sda_oe));
	itx_bus_model m (.scl_i(scl_line), .sda_i(sda_line), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = !sys_clk;
	end
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// The watchdog counts a hang as a mismatch.
	initial begin
		#3_000_000;
		failures++;
		end_of_test();
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Address phase held until hready, then the data phase held until hready again.
	task automatic bus_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge sys_clk);
		htrans <= 2'b10;
		haddr <= {20'h0_0000, a};
		hwrite <= wr;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
		q = hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus_xfer(1'b1, a, d, v);
	endtask
	task automatic expect_reg(input logic [11:0] a, input logic [31:0] exp);
		bus_xfer(1'b0, a, 32'h0000_0000, v);
		check(v, exp);
	endtask
	// Polls the status register until the event flag shows, under a bounded count.
	task automatic wait_code(input logic [7:0] code);
		int n;
		n = 0;
		bus_xfer(1'b0, `ITX_OFS_STAT, 32'h0000_0000, v);
		while (v[7:0] === `ITX_C_IDLE && n < 1000) begin
			bus_xfer(1'b0, `ITX_OFS_STAT, 32'h0000_0000, v);
			n++;
		end
		check(v, {24'h00_0000, code});
	endtask
	// Sends an unanswered write address as master, then ends the frame with STOP.
	task automatic finish_master();
		wr(`ITX_OFS_DATA, 32'h0000_0040);
		wr(`ITX_OFS_CTRL, 32'h0000_0001);
		wait_code(`ITX_C_MW_NAK);
		wr(`ITX_OFS_CTRL, 32'h0000_0005);
		repeat (300) @(posedge sys_clk);
	endtask
	initial begin
		reset_n = 1'b0;
		hsel = 1'b1;
		htrans = 2'b00;
		haddr = 32'h0000_0000;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		wr(12'h010, 32'h0000_00FF);
		expect_reg(12'h010, 32'h0000_0000);
		expect_reg(`ITX_OFS_CTRL, 32'h0000_0000);
		expect_reg(`ITX_OFS_STAT, 32'h0000_00F8);
		// The response and the line data outputs never leave zero.
		check({29'h0, hresp, scl_dout, sda_dout}, 32'h0);
		$display("test registers done");
		// Addressed for read: two bytes, the second marked final, then an ignored byte.
		wr(`ITX_OFS_OWN, 32'h0000_00A0);
		wr(`ITX_OFS_CTRL, 32'h0000_0001);
		m.start();
		m.send_byte(8'hA1, ack_n);
		check({31'h0, ack_n}, 32'h0);
		wait_code(`ITX_C_SL_SEL);
		repeat (20) @(posedge sys_clk);
		check({30'h0, scl_oe, scl_line}, 32'h2);
		wr(`ITX_OFS_DATA, 32'h0000_00A5);
		wr(`ITX_OFS_CTRL, 32'h0000_0001);
		m.recv_byte(b, 1'b0);
		check({24'h0, b}, 32'h0000_00A5);
		wait_code(`ITX_C_SL_ACK);
		wr(`ITX_OFS_DATA, 32'h0000_003C);
		wr(`ITX_OFS_CTRL, 32'h0000_0000);
		m.recv_byte(b, 1'b0);
		check({24'h0, b}, 32'h0000_003C);
		wait_code(`ITX_C_SL_LAST);
		wr(`ITX_OFS_CTRL, 32'h0000_0001);
		m.recv_byte(b, 1'b1);
		check({24'h0, b}, 32'h0000_00FF);
		m.stop();
		$display("test slave_read done");
		// Refused byte, then address recognition gated by acknowledge enable.
		m.start();
		m.send_byte(8'hA1, ack_n);
		wait_code(`ITX_C_SL_SEL);
		wr(`ITX_OFS_DATA, 32'h0000_0081);
		wr(`ITX_OFS_CTRL, 32'h0000_0001);
		m.recv_byte(b, 1'b1);
		wait_code(`ITX_C_SL_NAK);
		wr(`ITX_OFS_CTRL, 32'h0000_0000);
		m.stop();
		m.start();
		m.send_byte(8'hA1, ack_n);
		check({31'h0, ack_n}, 32'h1);
		expect_reg(`ITX_OFS_STAT, 32'h0000_00F8);
		m.stop();
		wr(`ITX_OFS_CTRL, 32'h0000_0001);
		m.start();
		m.send_byte(8'hA1, ack_n);
		check({31'h0, ack_n}, 32'h0);
		wait_code(`ITX_C_SL_SEL);
		$display("test slave_gate done");
		// A START three bits into a data byte is a bus error.
		wr(`ITX_OFS_DATA, 32'h0000_00FF);
		wr(`ITX_OFS_CTRL, 32'h0000_0001);
		repeat (3) m.read_bit(bit_v);
		m.start();
		wait_code(`ITX_C_BERR);
		check({30'h0, scl_oe, sda_oe}, 32'h0);
		wr(`ITX_OFS_CTRL, 32'h0000_0005);
		expect_reg(`ITX_OFS_CTRL, 32'h0000_0001);
		expect_reg(`ITX_OFS_STAT, 32'h0000_00F8);
		m.stop();
		$display("test bus_error done");
		// SDA obstructed on a free bus: extra clock pulses, then START once it is let go.
		m.hold_sda();
		wr(`ITX_OFS_CTRL, 32'h0000_0009);
		falls = 0;
		prev = 1'b1;
		repeat (700) begin
			@(posedge sys_clk);
			if (prev === 1'b1 && scl_line === 1'b0) falls++;
			prev = scl_line;
		end
		check({31'h0, falls >= 2}, 32'h1);
		m.release_all();
		wait_code(`ITX_C_STRT);
		finish_master();
		$display("test sda_obstruction done");
		// Bus held busy by a START with no STOP: only a forced access gets through.
		m.start();
		m.release_all();
		wr(`ITX_OFS_CTRL, 32'h0000_0009);
		repeat (400) @(posedge sys_clk);
		expect_reg(`ITX_OFS_STAT, 32'h0000_00F8);
		wr(`ITX_OFS_CTRL, 32'h0000_000D);
		wait_code(`ITX_C_STRT);
		bus_xfer(1'b0, `ITX_OFS_CTRL, 32'h0000_0000, v);
		check({31'h0, v[`ITX_B_STO]}, 32'h0);
		finish_master();
		$display("test forced_access done");
		end_of_test();
	end
endmodule
`default_nettype wire
